// *** rtl/epg_pkg.sv ***
package epg_pkg;

    // Clock and self-timed write cycle
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Geometry
    localparam int ADDR_BITS = 12;
    localparam int PAGE_BITS = 5;

    // Instruction codes
    localparam logic [7:0] STATUS_WRITE_INSTR = 8'h01;
    localparam logic [7:0] ARRAY_WRITE_INSTR  = 8'h02;
    localparam logic [7:0] ARRAY_READ_INSTR   = 8'h03;
    localparam logic [7:0] WRITE_DENY_INSTR   = 8'h04;
    localparam logic [7:0] STATUS_READ_INSTR  = 8'h05;
    localparam logic [7:0] WRITE_PERMIT_INSTR = 8'h06;

    // Status byte layout
    localparam int SR_PROT_EN_BIT = 7;
    localparam int SR_BP_LSB      = 2;
    localparam int SR_LATCH_BIT   = 1;
    localparam int SR_BUSY_BIT    = 0;

    // Values after reset
    localparam logic [1:0] BP_RESET      = 2'h0;
    localparam logic       PROT_EN_RESET = 1'b0;
    // Clock bit idles low so the edge detector sees no false edge after reset
    localparam logic [4:0] PIN_RESET     = 5'h1c;

    typedef enum logic [7:0] {
        ST_RESET    = 8'h01,
        ST_STANDBY  = 8'h02,
        ST_CMD      = 8'h04,
        ST_ADDR     = 8'h08,
        ST_DATA_IN  = 8'h10,
        ST_DATA_OUT = 8'h20,
        ST_ARMED    = 8'h40,
        ST_IGNORE   = 8'h80
    } epg_state_t;

endpackage : epg_pkg

// *** rtl/epg_mem_if.sv ***
`timescale 1ns/1ps
interface epg_mem_if #(
    parameter int AW = 12,
    parameter int DW = 8
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : epg_mem_if

// *** rtl/epg_mem.sv ***
`timescale 1ns/1ps
module epg_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // Clock
    input wire       clk,
    // Access port
    epg_mem_if.mem   port
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    // Registered read, no reset on contents
    always_ff @(posedge clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
        port.rdata <= store[port.raddr];
    end
endmodule : epg_mem

// *** rtl/epg_guard.sv ***
// Functional notes
// - Logic is held in reset while the supply detector reports low, enters standby on release.
// - Write permission starts cleared after power-on reset, so every write is refused.
// - After power-up a chip select fall is needed before the first instruction is decoded.
// - A completed array or status write clears the write permit latch automatically.
// - The self-timed write cycle starts on the chip select rise closing a write.
// - Array accesses during a write cycle are ignored and programming runs on.
// - Unknown instruction codes do nothing and the data output stays undriven.
// - Write permit sets the latch and its status bit; write deny clears it.
// - During a write cycle only the status read instruction is accepted.
// - The busy status bit is high during a write cycle and low otherwise.
`timescale 1ns/1ps
module epg_guard #(
    parameter int AW           = epg_pkg::ADDR_BITS,
    parameter int PW           = epg_pkg::PAGE_BITS,
    parameter int WRITE_CYCLES = epg_pkg::WRITE_CYCLES
) (
    // System
    input  wire logic ref_clk,
    input  wire logic rst,
    // Supply detector, high while supply is low
    input  wire logic por_low,
    // Serial link
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe,
    // State
    output logic      standby,
    output logic      write_busy
);
    localparam int NB = 1 << PW;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    generate
        if (WRITE_CYCLES < NB + 4 || AW <= PW + 2) begin : g_bad_param
            $error("epg_guard: write cycle too short or address too narrow");
        end
    endgenerate

    epg_mem_if #(.AW(AW), .DW(8)) arr_if ();
    epg_mem_if #(.AW(PW), .DW(8)) buf_if ();

    epg_mem #(.AW(AW), .DW(8)) u_array (
        .clk  (ref_clk),
        .port (arr_if)
    );
    epg_mem #(.AW(PW), .DW(8)) u_page (
        .clk  (ref_clk),
        .port (buf_if)
    );

    logic [4:0]          pin_meta;
    logic [4:0]          pin_sync;
    logic                cs_d;
    logic                sck_d;
    epg_pkg::epg_state_t state;
    logic [2:0]          bit_cnt;
    logic [7:0]          shift_in;
    logic [7:0]          op;
    logic                addr_hi;
    logic [AW-1:0]       addr;
    logic [5:0]          byte_cnt;
    logic [NB-1:0]       mask;
    logic [7:0]          pend_status;
    logic                latch;
    logic [1:0]          bp;
    logic                prot_en;
    logic                busy;
    logic                busy_sr;
    logic [CW-1:0]       busy_cnt;
    logic [PW:0]         copy_i;
    logic                copy_we;
    logic [PW-1:0]       copy_slot;
    logic [AW-PW-1:0]    page;
    logic [7:0]          out_sh;

    wire por_s    = pin_sync[4];
    wire wp_s     = pin_sync[3];
    wire cs_s     = pin_sync[2];
    wire sck_s    = pin_sync[1];
    wire si_s     = pin_sync[0];
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_rise  = cs_s & ~cs_d;
    wire cs_fall  = ~cs_s & cs_d;
    wire byte_end = sck_rise && (bit_cnt == 3'h7);
    wire sr_lock  = prot_en & ~wp_s;
    wire busy_end = busy && (busy_cnt == CW'(WRITE_CYCLES - 1));
    wire active   = (state != epg_pkg::ST_RESET) && (state != epg_pkg::ST_STANDBY);
    wire [7:0] next_shift = {shift_in[6:0], si_s};
    wire [7:0] status     = {prot_en, 3'h0, bp, latch, busy};

    function automatic logic page_protected(input logic [1:0] b, input logic [AW-1:0] a);
        case (b)
            2'h1:    page_protected = (a[AW-1:AW-2] == 2'h3);
            2'h2:    page_protected = a[AW-1];
            2'h3:    page_protected = 1'b1;
            default: page_protected = 1'b0;
        endcase
    endfunction : page_protected

    function automatic epg_pkg::epg_state_t decode(input logic [7:0] code, input logic bsy,
                                                   input logic wl, input logic lk);
        decode = epg_pkg::ST_IGNORE;
        if (code == epg_pkg::STATUS_READ_INSTR) begin
            decode = epg_pkg::ST_DATA_OUT;
        end else if (!bsy) begin
            case (code)
                epg_pkg::WRITE_PERMIT_INSTR: decode = epg_pkg::ST_ARMED;
                epg_pkg::WRITE_DENY_INSTR:   decode = epg_pkg::ST_ARMED;
                epg_pkg::ARRAY_READ_INSTR:   decode = epg_pkg::ST_ADDR;
                epg_pkg::ARRAY_WRITE_INSTR:  decode = wl ? epg_pkg::ST_ADDR : epg_pkg::ST_IGNORE;
                epg_pkg::STATUS_WRITE_INSTR: decode = (wl && !lk) ? epg_pkg::ST_DATA_IN
                                                                  : epg_pkg::ST_IGNORE;
                default:                     decode = epg_pkg::ST_IGNORE;
            endcase
        end
    endfunction : decode

    // Pins cross in through two flops; only the second stage is read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta <= epg_pkg::PIN_RESET;
            pin_sync <= epg_pkg::PIN_RESET;
            cs_d     <= 1'b1;
            sck_d    <= 1'b0;
        end else begin
            pin_meta <= {por_low, wp_n, cs_n, sck, si};
            pin_sync <= pin_meta;
            cs_d     <= cs_s;
            sck_d    <= sck_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || por_s) begin
            state <= epg_pkg::ST_RESET;
        end else begin
            case (state)
                epg_pkg::ST_RESET: begin
                    state <= epg_pkg::ST_STANDBY;
                end
                epg_pkg::ST_STANDBY: begin
                    if (cs_fall) begin
                        state <= epg_pkg::ST_CMD;
                    end
                end
                epg_pkg::ST_CMD: begin
                    if (cs_s) begin
                        state <= epg_pkg::ST_STANDBY;
                    end else if (byte_end) begin
                        state <= decode(next_shift, busy, latch, sr_lock);
                    end
                end
                epg_pkg::ST_ADDR: begin
                    if (cs_s) begin
                        state <= epg_pkg::ST_STANDBY;
                    end else if (byte_end && addr_hi) begin
                        state <= (op == epg_pkg::ARRAY_READ_INSTR) ? epg_pkg::ST_DATA_OUT
                                                                   : epg_pkg::ST_DATA_IN;
                    end
                end
                epg_pkg::ST_ARMED: begin
                    if (cs_s) begin
                        state <= epg_pkg::ST_STANDBY;
                    end else if (sck_rise) begin
                        state <= epg_pkg::ST_IGNORE;
                    end
                end
                epg_pkg::ST_DATA_IN, epg_pkg::ST_DATA_OUT, epg_pkg::ST_IGNORE: begin
                    if (cs_s) begin
                        state <= epg_pkg::ST_STANDBY;
                    end
                end
                default: begin
                    state <= epg_pkg::ST_RESET;
                end
            endcase
        end
    end

    // Bit framing and instruction capture
    always_ff @(posedge ref_clk) begin
        if (rst || !active || cs_s) begin
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
        end else if (sck_rise) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= next_shift;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op       <= 8'h00;
            addr_hi  <= 1'b0;
            addr     <= '0;
            byte_cnt <= 6'h00;
            mask     <= '0;
        end else if (state == epg_pkg::ST_CMD && byte_end) begin
            op       <= next_shift;
            addr_hi  <= 1'b0;
            byte_cnt <= 6'h00;
            if (next_shift == epg_pkg::ARRAY_WRITE_INSTR && !busy) begin
                mask <= '0;
            end
        end else if (state == epg_pkg::ST_ADDR && sck_rise) begin
            addr <= {addr[AW-2:0], si_s};
            if (byte_end) begin
                addr_hi <= 1'b1;
            end
        end else if (state == epg_pkg::ST_DATA_IN && byte_end) begin
            if (byte_cnt != 6'h3f) begin
                byte_cnt <= byte_cnt + 6'h01;
            end
            if (op == epg_pkg::ARRAY_WRITE_INSTR) begin
                mask[addr[PW-1:0]] <= 1'b1;
                addr[PW-1:0]       <= addr[PW-1:0] + PW'(1);
            end
        end else if (state == epg_pkg::ST_DATA_OUT && byte_end &&
                     op == epg_pkg::ARRAY_READ_INSTR) begin
            addr <= addr + AW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_status <= 8'h00;
        end else if (state == epg_pkg::ST_DATA_IN && byte_end &&
                     op == epg_pkg::STATUS_WRITE_INSTR) begin
            pend_status <= next_shift;
        end
    end

    // Page loads go to the buffer so a broken frame never reaches the array
    assign buf_if.we    = state == epg_pkg::ST_DATA_IN && byte_end &&
                          op == epg_pkg::ARRAY_WRITE_INSTR;
    assign buf_if.waddr = addr[PW-1:0];
    assign buf_if.wdata = next_shift;
    assign buf_if.raddr = copy_i[PW-1:0];

    // start on select rise; only at a byte boundary
    wire start_arr = cs_rise && state == epg_pkg::ST_DATA_IN && bit_cnt == 3'h0 &&
                     op == epg_pkg::ARRAY_WRITE_INSTR && byte_cnt != 6'h00 &&
                     !page_protected(bp, addr);
    wire start_sr  = cs_rise && state == epg_pkg::ST_DATA_IN && bit_cnt == 3'h0 &&
                     op == epg_pkg::STATUS_WRITE_INSTR && byte_cnt == 6'h01 && !sr_lock;

    // busy flag over the whole cycle; brown-out aborts it
    always_ff @(posedge ref_clk) begin
        if (rst || por_s) begin
            busy     <= 1'b0;
            busy_sr  <= 1'b0;
            busy_cnt <= '0;
            page     <= '0;
        end else if (!busy && (start_arr || start_sr)) begin
            busy     <= 1'b1;
            busy_sr  <= start_sr;
            busy_cnt <= '0;
            page     <= addr[AW-1:PW];
        end else if (busy_end) begin
            busy <= 1'b0;
        end else if (busy) begin
            busy_cnt <= busy_cnt + CW'(1);
        end
    end

    // copy runs from its own counter, untouched by the link
    always_ff @(posedge ref_clk) begin
        if (rst || !busy) begin
            copy_i    <= '0;
            copy_we   <= 1'b0;
            copy_slot <= '0;
        end else begin
            copy_we   <= !busy_sr && !copy_i[PW] && mask[copy_i[PW-1:0]];
            copy_slot <= copy_i[PW-1:0];
            if (!copy_i[PW]) begin
                copy_i <= copy_i + (PW + 1)'(1);
            end
        end
    end

    assign arr_if.we    = copy_we;
    assign arr_if.waddr = {page, copy_slot};
    assign arr_if.wdata = buf_if.rdata;
    assign arr_if.raddr = addr;

    // latch cleared at power-on; set and clear on select rise
    always_ff @(posedge ref_clk) begin
        if (rst || por_s) begin
            latch <= 1'b0;
        // auto clear when a write completes
        end else if (busy_end) begin
            latch <= 1'b0;
        end else if (cs_rise && state == epg_pkg::ST_ARMED) begin
            if (op == epg_pkg::WRITE_PERMIT_INSTR) begin
                latch <= 1'b1;
            end else if (op == epg_pkg::WRITE_DENY_INSTR) begin
                latch <= 1'b0;
            end
        end
    end

    // Protection bits held through brown-out as nonvolatile
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bp      <= epg_pkg::BP_RESET;
            prot_en <= epg_pkg::PROT_EN_RESET;
        end else if (busy_end && busy_sr) begin
            bp      <= pend_status[epg_pkg::SR_BP_LSB +: 2];
            prot_en <= pend_status[epg_pkg::SR_PROT_EN_BIT];
        end
    end

    // Shift out on falling edges; driver off outside data out
    always_ff @(posedge ref_clk) begin
        if (rst || state != epg_pkg::ST_DATA_OUT || cs_s) begin
            so     <= 1'b0;
            so_oe  <= 1'b0;
            out_sh <= 8'h00;
        end else begin
            so_oe <= 1'b1;
            if (sck_fall && bit_cnt == 3'h0) begin
                so     <= (op == epg_pkg::STATUS_READ_INSTR) ? status[7] : arr_if.rdata[7];
                out_sh <= (op == epg_pkg::STATUS_READ_INSTR) ? {status[6:0], 1'b0}
                                                             : {arr_if.rdata[6:0], 1'b0};
            end else if (sck_fall) begin
                so     <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            standby    <= 1'b0;
            write_busy <= 1'b0;
        end else begin
            standby    <= state == epg_pkg::ST_STANDBY;
            write_busy <= busy;
        end
    end

endmodule : epg_guard

// *** verif/epg_guard_monitor.sv ***
`timescale 1ns/1ps
module epg_guard_monitor #(
    parameter int WRITE_CYCLES = epg_pkg::WRITE_CYCLES
) (
    // System
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic por_low,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so,
    input wire logic so_oe,
    // State
    input wire logic standby,
    input wire logic write_busy
);
    int unsigned busy_len;
    int unsigned hi_age;

    always_ff @(posedge ref_clk) begin
        busy_len <= (rst || !write_busy) ? 0 : busy_len + 1;
    end

    // Saturates so a long idle never wraps
    always_ff @(posedge ref_clk) begin
        hi_age <= !cs_n ? 0 : (hi_age < 255 ? hi_age + 1 : hi_age);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || por_low);

    sequence s_arm;
        $fell(cs_n) && standby;
    endsequence
    sequence s_por_held;
        por_low [*6];
    endsequence

    chk_por_hold: assert property (disable iff (rst)
        s_por_held |-> !standby && !write_busy && !so_oe)
        else $error("outputs live in supply reset");
    chk_por_release: assert property (disable iff (rst)
        $fell(por_low) |-> ##[3:8] standby) else $error("no standby after supply reset");
    chk_busy_span: assert property (
        $fell(write_busy) |-> busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    chk_busy_start: assert property (
        $rose(write_busy) |-> cs_n && hi_age >= 2 && hi_age <= 8)
        else $error("busy without select rise");
    chk_oe_select: assert property (
        so_oe |-> hi_age <= 6) else $error("output driven while deselected");
    chk_so_quiet: assert property (
        !so_oe |-> !so) else $error("data output moves while undriven");
    chk_standby_wait: assert property (
        standby && cs_n |=> standby) else $error("standby left without select");
    chk_standby_leave: assert property (
        s_arm |-> ##[2:6] !standby) else $error("select fall not taken");
endmodule : epg_guard_monitor

bind epg_guard epg_guard_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_epg_guard_monitor (
    .ref_clk(ref_clk), .rst(rst), .por_low(por_low), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .standby(standby), .write_busy(write_busy));

// *** verif/epg_host.sv ***
`timescale 1ns/1ps
module epg_host (
    // Clock
    input  wire logic ref_clk,
    // Link
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // One selection, mode 0, n bits MSB first; rx keeps the last 8 bits read
    task automatic xfer(input logic [39:0] tx, input int n, output logic [7:0] rx,
                        output logic oe_seen);
        logic [39:0] sh;
        sh = tx << (40 - n);
        rx = 8'h00;
        oe_seen = 1'b0;
        @(posedge ref_clk) cs_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i <= n; i++) begin
            // Sampled late in the bit so a slow answer is still caught
            @(negedge ref_clk);
            // Undriven line reads inverted, so a missing driver shows up
            rx = {rx[6:0], so_oe ? so : ~so};
            oe_seen = oe_seen | so_oe;
            @(posedge ref_clk) sck <= 1'b0;
            if (i < n) begin
                si <= sh[39];
                sh = sh << 1;
                repeat (4) @(posedge ref_clk);
                sck <= 1'b1;
                repeat (3) @(posedge ref_clk);
            end
        end
        // select rise right after the last bit
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge ref_clk);
    endtask : xfer
endmodule : epg_host

// *** verif/tb_epg_guard.sv ***
`timescale 1ns/1ps
module tb_epg_guard;
    // Short write time keeps the run brief
    localparam int WC = 2000;
    logic       ref_clk;
    logic       rst;
    logic       por_low;
    logic       wp_n;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       so;
    logic       so_oe;
    logic       standby;
    logic       write_busy;
    logic [7:0] rx;
    logic       oe;
    int         n_fail;
    int         cmp_count;
    int         cycles;

    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    epg_guard #(.WRITE_CYCLES(WC)) u_epg_guard (.ref_clk(ref_clk), .rst(rst),
        .por_low(por_low), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so),
        .so_oe(so_oe), .standby(standby), .write_busy(write_busy));
    epg_host u_epg_host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic cmd(input logic [7:0] op);
        u_epg_host.xfer({32'h0, op}, 8, rx, oe);
    endtask : cmd
    task automatic stat;
        u_epg_host.xfer({24'h0, epg_pkg::STATUS_READ_INSTR, 8'h00}, 16, rx, oe);
    endtask : stat
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input int x);
        u_epg_host.xfer(40'({epg_pkg::ARRAY_WRITE_INSTR, 4'h0, a, d}) << x, 32 + x, rx, oe);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        u_epg_host.xfer({8'h0, epg_pkg::ARRAY_READ_INSTR, 4'h0, a, 8'h00}, 32, rx, oe);
    endtask : rd
    task automatic wait_idle;
        for (int i = 0; i < WC + 100 && write_busy !== 1'b0; i++) @(posedge ref_clk);
        chk1(write_busy, 1'b0);
    endtask : wait_idle

    task automatic t_power_up;
        chk1(standby, 1'b1);
        stat();
        chk8(rx, 8'h00);
    endtask : t_power_up
    task automatic t_refused;
        wr(12'h010, 8'h5a, 0);
        chk1(write_busy, 1'b0);
    endtask : t_refused
    task automatic t_permit;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        stat();
        chk8(rx, 8'h02);
        cmd(epg_pkg::WRITE_DENY_INSTR);
        stat();
        chk8(rx, 8'h00);
    endtask : t_permit
    task automatic t_write;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        wr(12'h010, 8'h5a, 0);
        chk1(write_busy, 1'b1);
        stat();
        chk8(rx, 8'h03);
        rd(12'h010);
        chk1(oe, 1'b0);
        wr(12'h010, 8'ha5, 0);
        wait_idle();
        stat();
        chk8(rx, 8'h00);
        rd(12'h010);
        chk8(rx, 8'h5a);
    endtask : t_write
    task automatic t_partial;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        wr(12'h010, 8'hc3, 4);
        chk1(write_busy, 1'b0);
        cmd(epg_pkg::WRITE_DENY_INSTR);
        rd(12'h010);
        chk8(rx, 8'h5a);
    endtask : t_partial
    task automatic t_bad_op;
        logic [7:0] ops[3] = '{8'h00, 8'h07, 8'hff};
        foreach (ops[i]) begin
            u_epg_host.xfer({24'h0, ops[i], 8'h00}, 16, rx, oe);
            chk1(oe, 1'b0);
        end
        stat();
        chk8(rx, 8'h00);
    endtask : t_bad_op
    task automatic t_por;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        wr(12'h020, 8'h11, 0);
        @(posedge ref_clk) por_low <= 1'b1;
        repeat (10) @(posedge ref_clk);
        chk1(write_busy, 1'b0);
        por_low <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk1(standby, 1'b1);
        stat();
        chk8(rx, 8'h00);
    endtask : t_por
    task automatic t_protect;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        u_epg_host.xfer({24'h0, epg_pkg::STATUS_WRITE_INSTR, 8'h8c}, 16, rx, oe);
        chk1(write_busy, 1'b1);
        wait_idle();
        stat();
        chk8(rx, 8'h8c);
        wp_n <= 1'b0;
        cmd(epg_pkg::WRITE_PERMIT_INSTR);
        u_epg_host.xfer({24'h0, epg_pkg::STATUS_WRITE_INSTR, 8'h00}, 16, rx, oe);
        chk1(write_busy, 1'b0);
        wr(12'h030, 8'h77, 0);
        chk1(write_busy, 1'b0);
        stat();
        chk8(rx, 8'h8e);
        wp_n <= 1'b1;
    endtask : t_protect

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            $display("BAD %0t run too long", $time);
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        por_low = 1'b0;
        wp_n = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        t_power_up();
        t_refused();
        t_permit();
        t_write();
        t_partial();
        t_bad_op();
        t_por();
        t_protect();
        conclude();
    end
endmodule : tb_epg_guard
